// File: src/mcct_pkg.sv
/*
 * Shared constants of the match/capture counter-timer: register offsets,
 * field positions, field codes and reset values.
 * Assumes a 32-bit APB master and byte addresses on paddr.
 */
// What this block does
// (R01) Chip holds two 32-bit and two 16-bit instances of this one design.
// (R02) Each instance has a prescaler as wide as its counter, ahead of it.
// (R03) Timer mode: counter advances once per prescaled system clock period.
// (R04) Mode select: timer, or counting edges of the external event input.
// (R05) Four independent match registers compared against the running count.
// (R06) Per match: keep counting, optionally flag an interrupt.
// (R07) Per match: halt the counter, optionally flag an interrupt.
// (R08) Per match: return counter to zero, optionally flag an interrupt.
// (R09) One capture channel copies the count when its input changes.
// (R10) Capture may flag an interrupt under a per-instance enable.
// (R11) Four match outputs, one tied to each match register.
// (R12) On match each output goes low, high, toggles, or stays.
// (R13) Match is count equal to value; reset/stop act at next count clock.
// (R14) Reset clears count, prescaler, matches, capture, flags, config; stopped.
package mcct_pkg;
	localparam int ADDR_W = 12;
	localparam int NUM_MATCH = 4;
	localparam int STS_W = 5;
	// register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_COUNT = 12'h004;
	localparam logic [11:0] OFS_PSC_LIM = 12'h008;
	localparam logic [11:0] OFS_PSC_CNT = 12'h00C;
	localparam logic [11:0] OFS_MCTRL = 12'h010;
	localparam logic [11:0] OFS_ECTRL = 12'h014;
	localparam logic [11:0] OFS_CAPT = 12'h018;
	localparam logic [11:0] OFS_ISTAT = 12'h01C;
	localparam logic [11:0] OFS_MATCH0 = 12'h020;
	localparam logic [11:0] OFS_MATCH3 = 12'h02C;
	localparam logic [11:0] OFS_IMASK = 12'h030;
	// control register fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_CRST = 1;
	localparam int CTRL_MODE_LO = 2;
	localparam int CTRL_CAPSEL_LO = 4;
	localparam int CTRL_CAPIE = 6;
	localparam int CTRL_W = 7;
	// count mode codes
	localparam logic [1:0] MODE_TIMER = 2'h0;
	localparam logic [1:0] MODE_RISE = 2'h1;
	localparam logic [1:0] MODE_FALL = 2'h2;
	localparam logic [1:0] MODE_BOTH = 2'h3;
	// match control: three bits per channel
	localparam int MC_STRIDE = 3;
	localparam int MC_IRQ = 0;
	localparam int MC_RST = 1;
	localparam int MC_STOP = 2;
	localparam int MC_W = 12;
	// output control: two action bits per channel, levels above
	localparam int EC_STRIDE = 2;
	localparam int EC_LVL_LO = 8;
	localparam int EC_W = 12;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	// status bit of the capture event, match events take bits 0..3
	localparam int STS_CAP = 4;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// File: src/pin_sync.sv
/*
 * Three-stage synchroniser for one pin with edge pulses.
 * Assumes the pin is asynchronous to pclk; the filtered level only moves
 * when the second and third stages agree.
 */
`timescale 1ns/1ps
module pin_sync (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pin side
	input wire logic pin,
	// filtered edges
	output logic rise,
	output logic fall
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic rise;
		logic fall;
	} sync_t;

	sync_t s_r;
	sync_t s_nxt;

	// first stage feeds only the second
	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = pin;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		s_nxt.rise = 1'b0;
		s_nxt.fall = 1'b0;
		if (s_r.s2 == s_r.s3 && s_r.s3 != s_r.lvl) begin
			s_nxt.lvl = s_r.s3;
			s_nxt.rise = s_r.s3;
			s_nxt.fall = ~s_r.s3;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rise = s_r.rise;
	assign fall = s_r.fall;
endmodule

// File: src/match_unit.sv
/*
 * One match comparator: equality level and a pulse when equality begins.
 * Assumes count and value are stable registers on pclk.
 */
`timescale 1ns/1ps
module match_unit #(
	parameter int WIDTH = 32
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// compared values
	input wire logic [WIDTH-1:0] count,
	input wire logic [WIDTH-1:0] value,
	// results
	output logic eq,
	output logic hit
);
	typedef struct packed {
		logic eq_prev;
	} mu_t;

	mu_t s_r;
	mu_t s_nxt;

	// a held equality raises only one event
	always_comb begin
		s_nxt = s_r;
		s_nxt.eq_prev = (count == value);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign eq = (count == value); // see (R13)
	assign hit = eq & ~s_r.eq_prev;
endmodule

// File: src/match_capture_timer.sv
/*
 * Counter/timer with prescaler, four match channels, one capture channel,
 * match outputs and a masked interrupt, as an APB slave.
 * Assumes one clock pclk at 25 MHz; count and capture pins are asynchronous.
 */
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
module match_capture_timer #(
	parameter int WIDTH = 32
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [mcct_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic count_in,
	input wire logic capture_in,
	output logic [mcct_pkg::NUM_MATCH-1:0] match_out,
	// interrupt
	output logic irq
);
	import mcct_pkg::*;

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [WIDTH-1:0] psc_lim;
		logic [WIDTH-1:0] psc_cnt;
		logic [WIDTH-1:0] count;
		logic [MC_W-1:0] mctrl;
		logic [EC_W-1:0] ectrl;
		logic [WIDTH-1:0] capt;
		logic [NUM_MATCH-1:0][WIDTH-1:0] mval;
		logic [STS_W-1:0] sts;
		logic [STS_W-1:0] msk;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic irq;
	} tmr_t;

	tmr_t s_r;
	tmr_t s_nxt;

	logic cnt_rise;
	logic cnt_fall;
	logic cap_rise;
	logic cap_fall;
	logic [NUM_MATCH-1:0] eq;
	logic [NUM_MATCH-1:0] hit;
	logic [1:0] mode;
	logic running;
	logic inc_evt;
	logic cnt_clk;
	logic cap_evt;
	logic [NUM_MATCH-1:0] rst_req;
	logic [NUM_MATCH-1:0] stop_req;
	logic [NUM_MATCH-1:0] irq_en;
	logic setup;
	logic wr;
	logic [STS_W-1:0] sts_set;
	logic [STS_W-1:0] sts_clr;

	// pins pass three flops before anything looks at them
	pin_sync u_cnt_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(count_in),
		.rise(cnt_rise),
		.fall(cnt_fall)
	);

	pin_sync u_cap_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(capture_in),
		.rise(cap_rise),
		.fall(cap_fall)
	);

	// one comparator per match register
	genvar gi;
	generate
		for (gi = 0; gi < NUM_MATCH; gi++) begin : g_match
			match_unit #(
				.WIDTH(WIDTH)
			) u_match (
				.pclk(pclk),
				.presetn(presetn),
				.count(s_r.count),
				.value(s_r.mval[gi]),
				.eq(eq[gi]),
				.hit(hit[gi])
			); // see (R05)
			assign rst_req[gi] = s_r.mctrl[gi*MC_STRIDE+MC_RST];
			assign stop_req[gi] = s_r.mctrl[gi*MC_STRIDE+MC_STOP];
			assign irq_en[gi] = s_r.mctrl[gi*MC_STRIDE+MC_IRQ];
		end
	endgenerate

	// count source select; the prescaler divides timer cycles or events alike
	always_comb begin
		mode = s_r.ctrl[CTRL_MODE_LO +: 2];
		running = s_r.ctrl[CTRL_EN] & ~s_r.ctrl[CTRL_CRST];
		if (mode == MODE_TIMER) begin
			inc_evt = 1'b1; // see (R03)
		end else if (mode == MODE_RISE) begin
			inc_evt = cnt_rise; // see (R04)
		end else if (mode == MODE_FALL) begin
			inc_evt = cnt_fall;
		end else begin
			inc_evt = cnt_rise | cnt_fall;
		end
		cnt_clk = running & inc_evt & (s_r.psc_cnt == s_r.psc_lim); // see (R02)
		cap_evt = (cap_rise & s_r.ctrl[CTRL_CAPSEL_LO]) | (cap_fall & s_r.ctrl[CTRL_CAPSEL_LO+1]);
		setup = psel & ~penable;
		wr = psel & penable & pwrite & s_r.ready;
	end

	// next state: bus writes first, then hardware events override
	always_comb begin
		s_nxt = s_r;
		sts_set = '0;
		sts_clr = '0;
		s_nxt.ready = setup;
		s_nxt.err = 1'b0;
		s_nxt.rdata = RST_WORD;
		// read data and error are prepared in the setup cycle
		if (setup) begin
			if (paddr == OFS_CTRL) begin
				s_nxt.rdata = 32'(s_r.ctrl);
			end else if (paddr == OFS_COUNT) begin
				s_nxt.rdata = 32'(s_r.count);
			end else if (paddr == OFS_PSC_LIM) begin
				s_nxt.rdata = 32'(s_r.psc_lim);
			end else if (paddr == OFS_PSC_CNT) begin
				s_nxt.rdata = 32'(s_r.psc_cnt);
			end else if (paddr == OFS_MCTRL) begin
				s_nxt.rdata = 32'(s_r.mctrl);
			end else if (paddr == OFS_ECTRL) begin
				s_nxt.rdata = 32'(s_r.ectrl);
			end else if (paddr == OFS_CAPT) begin
				s_nxt.rdata = 32'(s_r.capt);
			end else if (paddr == OFS_ISTAT) begin
				s_nxt.rdata = 32'(s_r.sts);
			end else if (paddr == OFS_IMASK) begin
				s_nxt.rdata = 32'(s_r.msk);
			end else if (paddr >= OFS_MATCH0 && paddr <= OFS_MATCH3 && paddr[1:0] == 2'h0) begin
				s_nxt.rdata = 32'(s_r.mval[paddr[3:2]]);
			end else begin
				s_nxt.err = 1'b1;
			end
		end
		// writes take effect at the access edge; read-only words ignore them
		if (wr) begin
			if (paddr == OFS_CTRL) begin
				s_nxt.ctrl = pwdata[CTRL_W-1:0];
			end else if (paddr == OFS_PSC_LIM) begin
				s_nxt.psc_lim = pwdata[WIDTH-1:0];
			end else if (paddr == OFS_MCTRL) begin
				s_nxt.mctrl = pwdata[MC_W-1:0];
			end else if (paddr == OFS_ECTRL) begin
				s_nxt.ectrl = pwdata[EC_W-1:0];
			end else if (paddr == OFS_ISTAT) begin
				sts_clr = pwdata[STS_W-1:0];
			end else if (paddr == OFS_IMASK) begin
				s_nxt.msk = pwdata[STS_W-1:0];
			end else if (paddr >= OFS_MATCH0 && paddr <= OFS_MATCH3 && paddr[1:0] == 2'h0) begin
				s_nxt.mval[paddr[3:2]] = pwdata[WIDTH-1:0];
			end
		end
		// held counter reset clears count and prescaler
		if (s_r.ctrl[CTRL_CRST]) begin
			s_nxt.count = '0;
			s_nxt.psc_cnt = '0;
		end else if (running && inc_evt) begin
			if (s_r.psc_cnt == s_r.psc_lim) begin
				s_nxt.psc_cnt = '0; // see (R02)
			end else begin
				s_nxt.psc_cnt = s_r.psc_cnt + 1'b1;
			end
		end
		// match actions land on the count clock after equality was seen
		if (cnt_clk) begin
			if (|(eq & stop_req)) begin
				s_nxt.ctrl[CTRL_EN] = 1'b0; // see (R07) (R13)
			end
			if (|(eq & rst_req)) begin
				s_nxt.count = '0; // see (R08) (R13)
			end else if (!(|(eq & stop_req))) begin
				s_nxt.count = s_r.count + 1'b1; // see (R03) (R06)
			end
		end
		// match events: flags and output actions
		for (int i = 0; i < NUM_MATCH; i++) begin
			if (hit[i]) begin
				sts_set[i] = irq_en[i]; // see (R06) (R07) (R08)
				case (s_r.ectrl[i*EC_STRIDE +: 2])
					ACT_LOW: s_nxt.ectrl[EC_LVL_LO+i] = 1'b0; // see (R12)
					ACT_HIGH: s_nxt.ectrl[EC_LVL_LO+i] = 1'b1;
					ACT_TOGGLE: s_nxt.ectrl[EC_LVL_LO+i] = ~s_r.ectrl[EC_LVL_LO+i];
					default: s_nxt.ectrl[EC_LVL_LO+i] = s_r.ectrl[EC_LVL_LO+i];
				endcase
			end
		end
		// capture snapshots the count as it stands
		if (cap_evt) begin
			s_nxt.capt = s_r.count; // see (R09)
			sts_set[STS_CAP] = s_r.ctrl[CTRL_CAPIE]; // see (R10)
		end
		// a new event beats a clear in the same cycle
		s_nxt.sts = (s_r.sts & ~sts_clr) | sts_set;
		s_nxt.irq = |(s_nxt.sts & s_nxt.msk);
	end

	// everything, config included, is cleared and stopped at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0; // see (R14)
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign prdata = s_r.rdata;
	assign pready = s_r.ready;
	assign pslverr = s_r.err;
	assign match_out = s_r.ectrl[EC_LVL_LO +: NUM_MATCH]; // see (R11)
	assign irq = s_r.irq;

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence seq_stop_edge;
		cnt_clk && |(eq & stop_req);
	endsequence

	sequence seq_halted;
		!s_r.ctrl[CTRL_EN] ##1 !s_r.ctrl[CTRL_EN];
	endsequence

	AST_WIDTH_FAMILY: assert property ( // see (R01)
		cnt_clk && (&s_r.count) && !(|(eq & (rst_req | stop_req))) |=> s_r.count == '0)
		else $error("counter did not wrap at its width");

	AST_PSC_WRAP: assert property ( // see (R02)
		running && inc_evt && s_r.psc_cnt == s_r.psc_lim && !wr |=> s_r.psc_cnt == '0)
		else $error("prescaler did not wrap at its limit");

	AST_TIMER_STEP: assert property ( // see (R03)
		cnt_clk && mode == MODE_TIMER && !(|(eq & (rst_req | stop_req)))
		|=> s_r.count == $past(s_r.count) + 1'b1)
		else $error("timer did not advance on count clock");

	AST_COUNT_HOLD: assert property ( // see (R04)
		mode != MODE_TIMER && !cnt_rise && !cnt_fall && !s_r.ctrl[CTRL_CRST] && !cnt_clk
		|=> $stable(s_r.count))
		else $error("counter moved without an input event");

	AST_MATCH_FLAG: assert property ( // see (R05) (R06)
		hit[0] && irq_en[0] |=> s_r.sts[0])
		else $error("match flag not raised");

	AST_STOP: assert property ( // see (R07) (R13)
		seq_stop_edge and !wr |=> seq_halted)
		else $error("counter not halted after match");

	AST_RESET_MATCH: assert property ( // see (R08) (R13)
		cnt_clk && |(eq & rst_req) && !wr |=> s_r.count == '0)
		else $error("counter not cleared after match");

	AST_CAPTURE: assert property ( // see (R09)
		cap_evt |=> s_r.capt == $past(s_r.count))
		else $error("capture value wrong");

	AST_CAP_IRQ: assert property ( // see (R10)
		cap_evt && s_r.ctrl[CTRL_CAPIE] && s_r.msk[STS_CAP] && !wr |=> irq)
		else $error("capture interrupt missing");

	AST_OUT_TOGGLE: assert property ( // see (R11) (R12)
		hit[3] && s_r.ectrl[3*EC_STRIDE +: 2] == ACT_TOGGLE && !wr |=> match_out[3] != $past(match_out[3]))
		else $error("match output did not toggle");

	AST_APB_ANSWER: assert property (
		setup |=> pready ##1 !pready)
		else $error("apb answer not one cycle after setup");

	AST_STATE_ZERO: assert property ( // see (R14)
		$rose(presetn) |-> s_r.count == '0 && !s_r.ctrl[CTRL_EN] && s_r.sts == '0)
		else $error("state not cleared by reset");

	// bus side: data and error only ever stand with the answer
	// error must come with ready, or a master would never see it
	AST_ERR_WITH_READY: assert property (
		pslverr |-> pready)
		else $error("slave error without ready");

	// idle read data is zero so a late sample never looks valid
	AST_RDATA_IDLE: assert property (
		!pready |-> prdata == '0)
		else $error("read data not zero outside the answer");

	// interrupt line follows masked status at every edge
	AST_IRQ_LEVEL: assert property ( // see (R06) (R10)
		irq == |(s_r.sts & s_r.msk))
		else $error("interrupt line differs from masked status");

	// a match without its enable never flags
	AST_NO_FLAG_OFF: assert property ( // see (R06)
		hit[0] && !irq_en[0] && !s_r.sts[0] |=> !s_r.sts[0])
		else $error("match flag raised while disabled");

	// prescaler counts up between wraps
	AST_PSC_STEP: assert property ( // see (R02)
		running && inc_evt && s_r.psc_cnt != s_r.psc_lim |=> s_r.psc_cnt == $past(s_r.psc_cnt) + 1'b1)
		else $error("prescaler did not step");

	// held counter reset keeps count and prescaler at zero
	AST_CRST_HOLD: assert property ( // see (R02) (R14)
		s_r.ctrl[CTRL_CRST] |=> s_r.count == '0 && s_r.psc_cnt == '0)
		else $error("counter reset not held");

	// counter mode advances once per count clock
	AST_EVENT_STEP: assert property ( // see (R04)
		cnt_clk && mode != MODE_TIMER && !(|(eq & (rst_req | stop_req)))
		|=> s_r.count == $past(s_r.count) + 1'b1)
		else $error("event count did not advance");

	// a stopped counter does not drift
	AST_HALTED_HOLD: assert property ( // see (R07)
		!s_r.ctrl[CTRL_EN] && !s_r.ctrl[CTRL_CRST] |=> $stable(s_r.count))
		else $error("halted counter moved");

	// capture register only moves on a capture event
	AST_CAP_HOLD: assert property ( // see (R09)
		!cap_evt |=> $stable(s_r.capt))
		else $error("capture changed without an event");

	// drive-low action
	AST_OUT_LOW: assert property ( // see (R12)
		hit[1] && s_r.ectrl[EC_STRIDE +: 2] == ACT_LOW && !wr |=> !match_out[1])
		else $error("match output not driven low");

	// drive-high action
	AST_OUT_HIGH: assert property ( // see (R12)
		hit[2] && s_r.ectrl[2*EC_STRIDE +: 2] == ACT_HIGH && !wr |=> match_out[2])
		else $error("match output not driven high");

	// do-nothing action keeps the level
	AST_OUT_KEEP: assert property ( // see (R12)
		hit[0] && s_r.ectrl[1:0] == ACT_NONE && !wr |=> match_out[0] == $past(match_out[0]))
		else $error("match output moved on a no-action match");
endmodule

// File: test/pin_partner.sv
/*
 * Far-side model of the timer pins: drives the event and capture inputs.
 * Assumes pclk from the bench; both pins idle low between pulses.
 */
`timescale 1ns/1ps
module pin_partner (
	// clock
	input wire logic pclk,
	// pins towards the timer
	output logic count_in,
	output logic capture_in
);
	// idle level at time zero
	initial begin
		count_in = 1'b0;
		capture_in = 1'b0;
	end
	// four cycles high, four low: wider than the three-flop filter needs
	task automatic pulse(input bit cap, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			if (cap)
				capture_in <= 1'b1;
			else
				count_in <= 1'b1;
			repeat (4) @(posedge pclk);
			capture_in <= 1'b0;
			count_in <= 1'b0;
			repeat (3) @(posedge pclk);
		end
	endtask
endmodule

// File: test/testbench.sv
/*
 * Self-checking bench for match_capture_timer: APB master tasks, integer
 * expectations, pin partner for the event and capture pins.
 * Assumes the register map and one-cycle APB answer of the design package.
 */
`timescale 1ns/1ps
module testbench;
	import mcct_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic count_in, capture_in;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] match_out;
	int errors, compares, seed, n;
	match_capture_timer #(.WIDTH(32)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .count_in(count_in), .capture_in(capture_in), .match_out(match_out), .irq(irq));
	pin_partner pins_u (.pclk(pclk), .count_in(count_in), .capture_in(capture_in));
	// bus clock, 40 ns period
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic tally_and_finish();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s exp %h got %h", name, exp, got);
		end
	endtask
	// reset held four cycles; also used mid-run to start each test clean
	task automatic reset_dut();
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	// one transfer; the bounded wait on pready guards against a hung slave
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			errors++;
			$display("[ERR] pready exp 1 got %b", pready);
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(name, exp, q);
	endtask
	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		errors = 0;
		compares = 0;
		seed = 32'h104b;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		reset_dut();
		rd("ctrl", OFS_CTRL, RST_WORD);
		rd("capt", OFS_CAPT, RST_WORD);
		rd("match3", OFS_MATCH3, RST_WORD);
		chk("pins", 32'h0, {27'h0, irq, match_out});
		wr(OFS_COUNT, 32'h55);
		rd("count", OFS_COUNT, RST_WORD);
		rd("unmapped", 12'h040, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		$display("test reset done");
		// timer: pass match0 with a flag, halt at match1
		reset_dut();
		wr(OFS_PSC_LIM, 32'h1);
		wr(OFS_MATCH0, 32'h2);
		wr(OFS_MATCH0 + 12'h004, 32'h6);
		wr(OFS_MCTRL, 32'h29);
		wr(OFS_CTRL, 32'h1);
		repeat (60) @(posedge pclk);
		rd("count", OFS_COUNT, 32'h6);
		rd("ctrl", OFS_CTRL, 32'h0);
		apb(1'b0, OFS_ISTAT, 32'h0);
		chk("flags", 32'h3, q & 32'h3);
		wr(OFS_IMASK, 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		wr(OFS_ISTAT, 32'h1);
		chk("irq", 32'h0, {31'h0, irq});
		$display("test timer done");
		// reset on match: the count must never pass the match value
		reset_dut();
		wr(OFS_MATCH0, 32'h4);
		wr(OFS_MCTRL, 32'h2);
		wr(OFS_CTRL, 32'h1);
		for (int i = 0; i < 12; i++) begin
			repeat ($unsigned($random(seed)) % 5) @(posedge pclk);
			apb(1'b0, OFS_COUNT, 32'h0);
			chk("wrap", 32'h1, {31'h0, q <= 32'h4});
		end
		$display("test wrap done");
		// every output action on one shared match, halted by match3
		reset_dut();
		for (int i = 0; i < 4; i++)
			wr(OFS_MATCH0 + 12'(4 * i), 32'h2);
		wr(OFS_ECTRL, 32'hBE4);
		wr(OFS_MCTRL, 32'h800);
		wr(OFS_CTRL, 32'h1);
		repeat (20) @(posedge pclk);
		chk("outs", 32'h5, {28'h0, match_out});
		rd("ectrl", OFS_ECTRL, 32'h5E4);
		rd("count", OFS_COUNT, 32'h2);
		$display("test outputs done");
		// counter mode with capture on rise and its interrupt
		reset_dut();
		n = 1 + ($unsigned($random(seed)) % 8);
		wr(OFS_CTRL, 32'h55);
		wr(OFS_IMASK, 32'h10);
		pins_u.pulse(1'b0, n);
		pins_u.pulse(1'b1, 1);
		repeat (8) @(posedge pclk);
		rd("count", OFS_COUNT, 32'(n));
		rd("capt", OFS_CAPT, 32'(n));
		chk("irq", 32'h1, {31'h0, irq});
		wr(OFS_ISTAT, 32'h10);
		chk("irq", 32'h0, {31'h0, irq});
		$display("test capture done");
		tally_and_finish();
	end
endmodule
